// file: shared/nimg_pkg.sv
`default_nettype none
package nimg_pkg;
   // ****************************************************************
   // Register map
   // ****************************************************************
   localparam logic [11:0] NIMG_STATUS_OFF = 12'hC14;
   localparam logic [11:0] NIMG_MASK_OFF = 12'hC1C;
   localparam int NIMG_ADDR_W = 12;
   localparam int NIMG_DATA_W = 32;
   localparam int NIMG_SRC_N = 9;

   // ****************************************************************
   // Field positions
   // ****************************************************************
   localparam int NIMG_TX_DONE_BIT = 0;
   localparam int NIMG_TX_IDLE_BIT = 1;
   localparam int NIMG_TX_BUFFER_MISSING_BIT = 2;
   localparam int NIMG_RX_EARLY_BIT = 3;
   localparam int NIMG_RX_FAULT_BIT = 4;
   localparam int NIMG_TX_UNDERFLOW_BIT = 5;
   localparam int NIMG_RX_DONE_BIT = 6;
   localparam int NIMG_RX_BUFFER_MISSING_BIT = 7;
   localparam int NIMG_RX_IDLE_BIT = 8;
   localparam int NIMG_RESERVED_BIT = 9;
   localparam int NIMG_ABNORMAL_BIT = 15;
   localparam int NIMG_NORMAL_BIT = 16;

   // Sources that belong to each group, one bit per source.
   localparam logic [8:0] NIMG_NORMAL_SRCS = 9'h045;
   localparam logic [8:0] NIMG_ABNORMAL_SRCS = 9'h1BA;

   // Bits of the mask that software can change; all others read as zero.
   localparam logic [31:0] NIMG_MASK_WR = 32'h000181FF;

   // ****************************************************************
   // Values after reset
   // ****************************************************************
   localparam logic [31:0] NIMG_MASK_RST = 32'h00000000;
   localparam logic [8:0] NIMG_STATUS_RST = 9'h000;
   localparam logic [31:0] NIMG_RDATA_RST = 32'h00000000;
endpackage
`default_nettype wire

// file: src/nimg_irq_gate.sv
// Notes on behaviour
// - The receive-idle source raises the interrupt only with mask bit 8, group bit 15 and its flag set.
// - The receive-buffer-missing source raises it only with mask bit 7, group bit 15 and its flag set.
// - The receive-done source raises it only with mask bit 6, group bit 16 and its flag set.
// - The transmit-underflow source raises it only with mask bit 5, group bit 15 and its flag set.
// - The receive-fault source raises it only with mask bit 4, group bit 15 and its flag set.
// - The receive-early source raises it only with mask bit 3, group bit 15 and its flag set.
// - The transmit-buffer-missing source raises it only with mask bit 2, group bit 16 and its flag set.
// - The transmit-idle source raises it only with mask bit 1, group bit 15 and its flag set.
// - The transmit-done source raises it only with mask bit 0, group bit 16 and its flag set.
// - Mask bit 9 is read-only and always reads zero whatever is written.
// - With group bit 16 clear no normal-group source can raise the interrupt.
// - With group bit 15 clear no abnormal-group source can raise the interrupt.
//
// Local design decision: the AHB-Lite register port.
`timescale 1ns/10ps
`default_nettype none
module nimg_irq_gate
(
   // Clock, reset and enable
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic clk_en,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [nimg_pkg::NIMG_ADDR_W-1:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [nimg_pkg::NIMG_DATA_W-1:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [nimg_pkg::NIMG_DATA_W-1:0] hrdata,
   // Event pulses from the controller, one per source
   input wire logic [nimg_pkg::NIMG_SRC_N-1:0] src_event,
   // Interrupt line to the host
   output logic irq
);
   import nimg_pkg::*;

   // ****************************************************************
   // Per-source qualification
   // ****************************************************************
   function automatic logic [8:0] qualify(input logic [8:0] flags, input logic [31:0] mask);
      logic [8:0] grp;
      grp = ({9{mask[NIMG_NORMAL_BIT]}} & NIMG_NORMAL_SRCS)
          | ({9{mask[NIMG_ABNORMAL_BIT]}} & NIMG_ABNORMAL_SRCS);
      return flags & mask[8:0] & grp;
   endfunction

   logic [31:0] mask_q;
   logic [8:0] status_q;
   logic [8:0] status_d;
   logic [8:0] qual;
   logic wr_pend_q;
   logic [11:0] wr_addr_q;
   logic [31:0] rdata_q;
   logic addr_ok;
   logic [31:0] status_view;

   // ****************************************************************
   // Bus slave
   // ****************************************************************
   // Zero wait states; a frozen block holds the bus off instead of losing a transfer.
   assign hreadyout = clk_en;
   assign hresp = 1'b0;
   assign hrdata = rdata_q;
   assign addr_ok = hsel && htrans[1] && hready && clk_en;

   assign status_view = {15'h0, |(status_q & NIMG_NORMAL_SRCS),
                         |(status_q & NIMG_ABNORMAL_SRCS), 6'h00, status_q};

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         wr_pend_q <= 1'b0;
         wr_addr_q <= 12'h000;
      end
      else if (clk_en)
      begin
         wr_pend_q <= addr_ok && hwrite;
         wr_addr_q <= haddr;
      end
   end

   // Read data is loaded at the address phase so it comes straight from flip-flops.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         rdata_q <= NIMG_RDATA_RST;
      else if (clk_en)
      begin
         if (addr_ok && !hwrite && haddr == NIMG_MASK_OFF)
            rdata_q <= mask_q;
         else if (addr_ok && !hwrite && haddr == NIMG_STATUS_OFF)
            rdata_q <= status_view;
         else
            rdata_q <= NIMG_RDATA_RST;
      end
   end

   // ****************************************************************
   // Mask register
   // ****************************************************************
   // A read taken in the data phase of a mask write returns the old value, so do not chain them.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         mask_q <= NIMG_MASK_RST;
      else if (clk_en && wr_pend_q && wr_addr_q == NIMG_MASK_OFF)
         mask_q <= hwdata & NIMG_MASK_WR;
   end

   // ****************************************************************
   // Sticky status, write one to clear
   // ****************************************************************
   // An event in the clearing cycle survives, since the set term is ORed last.
   always_comb
   begin
      status_d = status_q;
      if (wr_pend_q && wr_addr_q == NIMG_STATUS_OFF)
         status_d = status_q & ~hwdata[8:0];
      status_d = status_d | src_event;
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         status_q <= NIMG_STATUS_RST;
      else if (clk_en)
         status_q <= status_d;
   end

   // ****************************************************************
   // Interrupt line
   // ****************************************************************
   assign qual = qualify(status_q, mask_q);
   assign irq = |qual;

   // ****************************************************************
   // Checks
   // ****************************************************************
   sequence s_mask_write;
      addr_ok && hwrite && haddr == NIMG_MASK_OFF;
   endsequence

   sequence s_mask_read;
      addr_ok && !hwrite && haddr == NIMG_MASK_OFF;
   endsequence

   sequence s_status_read;
      addr_ok && !hwrite && haddr == NIMG_STATUS_OFF;
   endsequence

   sequence s_status_write;
      addr_ok && hwrite && haddr == NIMG_STATUS_OFF;
   endsequence

   property p_rx_idle;
      @(posedge hclk) disable iff (!hresetn)
      (status_q[8] && mask_q[8] && mask_q[15]) |-> irq;
   endproperty
   a_rx_idle: assert property (p_rx_idle) else $error("rx idle not raised");

   property p_rx_buf;
      @(posedge hclk) disable iff (!hresetn)
      (status_q[7] && mask_q[7] && mask_q[15]) |-> irq;
   endproperty
   a_rx_buf: assert property (p_rx_buf) else $error("rx buffer missing not raised");

   property p_rx_done;
      @(posedge hclk) disable iff (!hresetn)
      (status_q[6] && mask_q[6] && mask_q[16]) |-> irq;
   endproperty
   a_rx_done: assert property (p_rx_done) else $error("rx done not raised");

   property p_tx_uf;
      @(posedge hclk) disable iff (!hresetn)
      (status_q[5] && mask_q[5] && mask_q[15]) |-> irq;
   endproperty
   a_tx_uf: assert property (p_tx_uf) else $error("tx underflow not raised");

   property p_rx_fault;
      @(posedge hclk) disable iff (!hresetn)
      (status_q[4] && mask_q[4] && mask_q[15]) |-> irq;
   endproperty
   a_rx_fault: assert property (p_rx_fault) else $error("rx fault not raised");

   property p_rx_early;
      @(posedge hclk) disable iff (!hresetn)
      (status_q[3] && mask_q[3] && mask_q[15]) |-> irq;
   endproperty
   a_rx_early: assert property (p_rx_early) else $error("rx early not raised");

   property p_tx_buf;
      @(posedge hclk) disable iff (!hresetn)
      (status_q[2] && mask_q[2] && mask_q[16]) |-> irq;
   endproperty
   a_tx_buf: assert property (p_tx_buf) else $error("tx buffer missing not raised");

   property p_tx_idle;
      @(posedge hclk) disable iff (!hresetn)
      (status_q[1] && mask_q[1] && mask_q[15]) |-> irq;
   endproperty
   a_tx_idle: assert property (p_tx_idle) else $error("tx idle not raised");

   property p_tx_done;
      @(posedge hclk) disable iff (!hresetn)
      (status_q[0] && mask_q[0] && mask_q[16]) |-> irq;
   endproperty
   a_tx_done: assert property (p_tx_done) else $error("tx done not raised");

   property p_reserved;
      @(posedge hclk) disable iff (!hresetn)
      s_mask_read ##1 clk_en [*1] |-> !hrdata[9] && !mask_q[9];
   endproperty
   a_reserved: assert property (p_reserved) else $error("reserved mask bit read high");

   property p_mask_update;
      @(posedge hclk) disable iff (!hresetn)
      s_mask_write ##1 clk_en |=> mask_q[16:15] == $past(hwdata[16:15]) && !mask_q[9];
   endproperty
   a_mask_update: assert property (p_mask_update) else $error("mask write lost");

   property p_normal_off;
      @(posedge hclk) disable iff (!hresetn)
      !mask_q[16] && !(|(status_q & mask_q[8:0] & NIMG_ABNORMAL_SRCS & {9{mask_q[15]}}))
      |-> !irq;
   endproperty
   a_normal_off: assert property (p_normal_off) else $error("normal group leaked");

   property p_abnormal_off;
      @(posedge hclk) disable iff (!hresetn)
      !mask_q[15] && !(|(status_q & mask_q[8:0] & NIMG_NORMAL_SRCS & {9{mask_q[16]}}))
      |-> !irq;
   endproperty
   a_abnormal_off: assert property (p_abnormal_off) else $error("abnormal group leaked");

   property p_irq_hold;
      @(posedge hclk) disable iff (!hresetn)
      (irq && !clk_en) |=> irq;
   endproperty
   a_irq_hold: assert property (p_irq_hold) else $error("irq dropped while frozen");

   property p_irq_or;
      @(posedge hclk) disable iff (!hresetn)
      irq |-> |(status_q & mask_q[8:0]) && (mask_q[15] || mask_q[16]);
   endproperty
   a_irq_or: assert property (p_irq_or) else $error("irq without a qualified source");

   // ****************************************************************
   // Checks on the bus read path
   // ****************************************************************
   // Status is read as it stood at the address phase, so a read racing an event sees old flags.
   property p_status_read;
      @(posedge hclk) disable iff (!hresetn)
      s_status_read ##1 clk_en |-> hrdata[8:0] == $past(status_q) && hrdata[14:9] == 6'h00
         && hrdata[16] == ($past(status_q[0]) || $past(status_q[2]) || $past(status_q[6]))
         && hrdata[15] == ($past(status_q[1]) || $past(status_q[3]) || $past(status_q[4])
         || $past(status_q[5]) || $past(status_q[7]) || $past(status_q[8]));
   endproperty
   a_status_read: assert property (p_status_read) else $error("status read wrong");

   property p_hrdata_idle;
      @(posedge hclk) disable iff (!hresetn)
      clk_en && !(addr_ok && !hwrite) |=> hrdata == 32'h00000000;
   endproperty
   a_hrdata_idle: assert property (p_hrdata_idle) else $error("read data left standing");

   // ****************************************************************
   // Checks on the status flags and the freeze
   // ****************************************************************
   // An event that meets a clear in the same cycle must survive, or the host would miss it.
   property p_set_wins;
      @(posedge hclk) disable iff (!hresetn)
      clk_en && |src_event |=> (status_q & $past(src_event)) == $past(src_event);
   endproperty
   a_set_wins: assert property (p_set_wins) else $error("event lost");

   property p_status_clear;
      @(posedge hclk) disable iff (!hresetn)
      s_status_write ##1 (clk_en && src_event == 9'h000)
      |=> (status_q & $past(hwdata[8:0])) == 9'h000;
   endproperty
   a_status_clear: assert property (p_status_clear) else $error("status not cleared");

   property p_freeze;
      @(posedge hclk) disable iff (!hresetn)
      !clk_en |=> $stable(mask_q) && $stable(status_q) && $stable(hrdata);
   endproperty
   a_freeze: assert property (p_freeze) else $error("state moved while frozen");

   // Written out bit by bit so that a fault in the group tables cannot hide here.
   property p_irq_only;
      @(posedge hclk) disable iff (!hresetn)
      irq |-> (status_q[8] && mask_q[8] && mask_q[15])
         || (status_q[7] && mask_q[7] && mask_q[15])
         || (status_q[6] && mask_q[6] && mask_q[16])
         || (status_q[5] && mask_q[5] && mask_q[15])
         || (status_q[4] && mask_q[4] && mask_q[15])
         || (status_q[3] && mask_q[3] && mask_q[15])
         || (status_q[2] && mask_q[2] && mask_q[16])
         || (status_q[1] && mask_q[1] && mask_q[15])
         || (status_q[0] && mask_q[0] && mask_q[16]);
   endproperty
   a_irq_only: assert property (p_irq_only) else $error("irq raised by an unqualified source");
endmodule
`default_nettype wire

// file: tb/nimg_event_src.sv
`timescale 1ns/10ps
`default_nettype none
// ****************************************************************
// Event source standing in for the controller
// ****************************************************************
module nimg_event_src
(
   // Clock
   input wire logic hclk,
   // Event pulses, one per source
   output logic [8:0] src_event
);
   initial src_event = 9'h000;
   // Single-cycle pulses, so that only a truly sticky status bit can hold the line.
   task automatic pulse(input logic [8:0] m);
      @(posedge hclk);
      src_event <= m;
      @(posedge hclk);
      src_event <= 9'h000;
   endtask
endmodule
`default_nettype wire

// file: tb/nic_interrupt_mask_gating_bench.sv
`timescale 1ns/10ps
`default_nettype none
module nic_interrupt_mask_gating_bench;
   import nimg_pkg::*;
   // ****************************************************************
   // Signals
   // ****************************************************************
   localparam logic [8:0] NORM_SRCS = 9'h045;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic [11:0] haddr = 12'h000;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic clk_en = 1'b1;
   logic [31:0] hwdata = 32'h00000000;
   logic hreadyout;
   logic hresp;
   logic irq;
   logic [31:0] hrdata;
   logic [8:0] src_event;
   logic [31:0] rd;
   logic [31:0] grp;
   int n_mismatch = 0;
   int n_compared = 0;
   always #2.5 hclk = ~hclk;
   nimg_irq_gate u_nimg_irq_gate (.hclk(hclk), .hresetn(hresetn), .clk_en(clk_en),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
      .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
      .hrdata(hrdata), .src_event(src_event), .irq(irq));
   nimg_event_src u_nimg_event_src (.hclk(hclk), .src_event(src_event));
   // ****************************************************************
   // Tasks
   // ****************************************************************
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wait_ready();
      @(posedge hclk);
      while (hreadyout !== 1'b1)
      begin
         @(posedge hclk);
      end
   endtask
   // Read data is taken at the closing edge, before that edge's updates land.
   task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= wr;
      wait_ready();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      wait_ready();
      rd = hrdata;
      check("hresp", 32'h00000000, {31'h0, hresp});
   endtask
   task automatic check_irq(input logic exp);
      #1;
      check("irq", {31'h0, exp}, {31'h0, irq});
   endtask
   task automatic tally_and_finish();
      $display("compared %0d mismatched %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // ****************************************************************
   // Tests
   // ****************************************************************
   initial
   begin
      repeat (5000) @(posedge hclk);
      n_mismatch++;
      tally_and_finish();
   end
   initial
   begin
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      xfer(1'b0, NIMG_MASK_OFF, 32'h00000000);
      check("mask reset", 32'h00000000, rd);
      xfer(1'b1, NIMG_MASK_OFF, 32'hFFFFFFFF);
      xfer(1'b0, NIMG_MASK_OFF, 32'h00000000);
      check("mask readback", 32'h000181FF, rd);
      check_irq(1'b0);
      xfer(1'b1, 12'h000, 32'hFFFFFFFF);
      xfer(1'b0, 12'h000, 32'h00000000);
      check("unmapped", 32'h00000000, rd);
      $display("test registers done");
      for (int i = 0; i < 9; i++)
      begin
         grp = NORM_SRCS[i] ? 32'h00010000 : 32'h00008000;
         xfer(1'b1, NIMG_MASK_OFF, grp | (32'h1 << i));
         u_nimg_event_src.pulse(9'h001 << i);
         check_irq(1'b1);
         xfer(1'b0, NIMG_STATUS_OFF, 32'h00000000);
         check("status", grp | (32'h1 << i), rd);
         xfer(1'b1, NIMG_MASK_OFF, (grp ^ 32'h00018000) | (32'h1 << i));
         check_irq(1'b0);
         xfer(1'b1, NIMG_MASK_OFF, grp | (32'h1FF ^ (32'h1 << i)));
         check_irq(1'b0);
         xfer(1'b1, NIMG_MASK_OFF, grp | (32'h1 << i));
         check_irq(1'b1);
         xfer(1'b1, NIMG_STATUS_OFF, 32'h1 << i);
         check_irq(1'b0);
      end
      $display("test per-source gating done");
      xfer(1'b1, NIMG_MASK_OFF, 32'h000181FF);
      u_nimg_event_src.pulse(9'h101);
      xfer(1'b1, NIMG_STATUS_OFF, 32'h00000001);
      check_irq(1'b1);
      xfer(1'b1, NIMG_STATUS_OFF, 32'h00000100);
      check_irq(1'b0);
      $display("test combined sources done");
      // The event lands in the data phase of its own clear, so the flag must stay set.
      u_nimg_event_src.pulse(9'h001);
      check_irq(1'b1);
      fork
         xfer(1'b1, NIMG_STATUS_OFF, 32'h00000001);
         begin
            @(posedge hclk);
            u_nimg_event_src.pulse(9'h001);
         end
      join
      check_irq(1'b1);
      xfer(1'b0, NIMG_STATUS_OFF, 32'h00000000);
      check("status after set and clear", 32'h00010001, rd);
      xfer(1'b1, NIMG_STATUS_OFF, 32'h00000001);
      check_irq(1'b0);
      $display("test set over clear done");
      // While frozen an event is lost and the line holds its level.
      u_nimg_event_src.pulse(9'h004);
      check_irq(1'b1);
      @(posedge hclk);
      clk_en <= 1'b0;
      u_nimg_event_src.pulse(9'h100);
      repeat (3) @(posedge hclk);
      check_irq(1'b1);
      check("hreadyout frozen", 32'h00000000, {31'h0, hreadyout});
      @(posedge hclk);
      clk_en <= 1'b1;
      xfer(1'b0, NIMG_STATUS_OFF, 32'h00000000);
      check("status after freeze", 32'h00010004, rd);
      $display("test clock enable done");
      @(posedge hclk);
      hresetn <= 1'b0;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      check_irq(1'b0);
      xfer(1'b0, NIMG_MASK_OFF, 32'h00000000);
      check("mask after reset", 32'h00000000, rd);
      xfer(1'b0, NIMG_STATUS_OFF, 32'h00000000);
      check("status after reset", 32'h00000000, rd);
      $display("test reset in mid-run done");
      tally_and_finish();
   end
endmodule
`default_nettype wire
